// [hw/sclt_pkg.sv]
// types shared by the statistics counters and learned table read block
// assumes sclt_regs.svh supplies the register offsets, field positions, codes and length limits
package sclt_pkg;

   // one received frame, reported at its completion
   typedef struct packed {
      logic        done;
      logic [10:0] len;
      logic        crcOk;
      logic        symErr;
      logic        dribble;
      logic        preambleOk;
      logic        highPrio;
      logic        bcast;
      logic        mcast;
      logic [15:0] etherType;
      logic [15:0] opcode;
      logic        daPause;
   } sclt_rx_type;

   // one transmitted frame or late collision event
   typedef struct packed {
      logic        done;
      logic [10:0] len;
      logic        good;
      logic        highPrio;
      logic        pause;
      logic        lateCol;
   } sclt_tx_type;

   // learned table fetch state
   typedef enum logic [0:0] {
      SCLT_IDLE = 1'b0,
      SCLT_WAIT = 1'b1
   } sclt_fetch_type;

endpackage

// [hw/sclt_regs.svh]
// register offsets, field positions and codes for the statistics counters
// and learned address table read block; definitions only
`ifndef SCLT_REGS_SVH
`define SCLT_REGS_SVH

// indirect access registers (register port addresses)
`define SCLT_REG_IND_CTL      8'h6e
`define SCLT_REG_IND_ADDR     8'h6f
`define SCLT_REG_DATA_FIRST   8'h70
`define SCLT_REG_DATA_LAST    8'h78

// indirect control register fields
`define SCLT_CTL_READ_BIT     4
`define SCLT_CTL_SEL_HI       3
`define SCLT_CTL_SEL_LO       2
`define SCLT_CTL_ADDR_HI      1
`define SCLT_CTL_CODE_DYN_RD  8'h18
`define SCLT_SEL_LEARNED      2'h2
`define SCLT_SEL_COUNTERS     2'h3

// learned entry layout
`define SCLT_ENT_EMPTY_BIT    71
`define SCLT_ENT_COUNT_HI     70
`define SCLT_ENT_COUNT_LO     61
`define SCLT_ENT_NOTRDY_BIT   55
`define SCLT_ENT_FIRST_ADDR   10'h000

// counter word layout
`define SCLT_CW_OVF_BIT       31
`define SCLT_CW_VALID_BIT     30
`define SCLT_CW_VALUE_HI      29

// counter offsets, port 1; each further port sits 0x20 higher
`define SCLT_PORT_STRIDE      10'h020
`define SCLT_OFS_RX_LO_OCT    10'h020
`define SCLT_OFS_RX_HI_OCT    10'h021
`define SCLT_OFS_RX_SHORT_OK  10'h022
`define SCLT_OFS_RX_SHORT_BAD 10'h023
`define SCLT_OFS_RX_LONG_OK   10'h024
`define SCLT_OFS_RX_LONG_BAD  10'h025
`define SCLT_OFS_RX_BAD_SYM   10'h026
`define SCLT_OFS_RX_BAD_CRC   10'h027
`define SCLT_OFS_RX_MISALIGN  10'h028
`define SCLT_OFS_RX_CTRL      10'h029
`define SCLT_OFS_RX_PAUSE     10'h02a
`define SCLT_OFS_RX_BCAST     10'h02b
`define SCLT_OFS_RX_MCAST     10'h02c
`define SCLT_OFS_RX_UCAST     10'h02d
`define SCLT_OFS_RX_LEN_64    10'h02e
`define SCLT_OFS_RX_LEN_65    10'h02f
`define SCLT_OFS_RX_LEN_128   10'h030
`define SCLT_OFS_RX_LEN_256   10'h031
`define SCLT_OFS_RX_LEN_512   10'h032
`define SCLT_OFS_RX_LEN_1024  10'h033
`define SCLT_OFS_TX_LO_OCT    10'h034
`define SCLT_OFS_TX_HI_OCT    10'h035
`define SCLT_OFS_TX_LATE_COL  10'h036
`define SCLT_OFS_TX_PAUSE     10'h037
`define SCLT_NUM_COUNTERS     24

// frame length limits in bytes, control frame ether type and pause opcode
`define SCLT_LEN_MIN          11'd64
`define SCLT_LEN_MAX_STD      11'd1522
`define SCLT_LEN_MAX_BIG      11'd1536
`define SCLT_LEN_JABBER       11'd1916
`define SCLT_ETYPE_CTRL       16'h8808
`define SCLT_OPCODE_PAUSE     16'h0001

`endif

// [hw/sclt_stats_table.sv]
// per-port statistics counters and indirect read of the learned table
// assumes register port, frame events and table port are all on clk_sys
//
// Overview of operation
// - control code 0x18 in register 110 selects a learned table read
// - writing register 111 starts the selected read
// - ten-bit entry address: high bits in 110, low byte in 111
// - entry shown in registers 112..120, most significant byte first
// - reading entry zero also reports the learned entry count in 112/113
// - bit 55 reads one until the entry data are valid
// - count field bits 70-61 plus empty flag bit 71 encode count
// - each port keeps its own counter set, read by counter offset
// - counter word: overflow bit 31, valid bit 30, value 29-0
// - 0x20/0x21 add received low/high priority octets, bad frames too
// - 0x22 counts short received frames with good crc
// - 0x23 counts short frames with bad crc, symbol or alignment error
// - 0x24 counts error-free frames over the configured maximum, up to 1916 bytes
// - 0x25 counts errored over-maximum frames and any over 1916 bytes
// - 0x26 counts legal-size frames with a bad data symbol and a good preamble
// - 0x27 counts legal-size whole-byte frames with bad crc
// - 0x28 counts legal-size non-whole-byte frames with bad crc
// - 0x29 counts received frames of type 88-08
// - 0x2a counts qualified pause frames received
// - 0x2b..0x2d count good broadcast, non-control multicast and unicast frames
// - 0x2e..0x33 bin legal-size received frames by length
// - 0x34/0x35 add transmitted good low/high priority octets
// - 0x36 counts late collisions
// - 0x37 counts transmitted pause frames
`timescale 1ns/1ns
`include "sclt_regs.svh"

module sclt_stats_table #(
   parameter int PORTS = 1
) (
   // clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       rst,
   // register port
   input  wire logic [7:0]                 regAddr,
   input  wire logic                       regWr,
   input  wire logic [7:0]                 regWrData,
   output logic      [7:0]                 regRdData,
   // configuration
   input  wire logic                       maxLen1536,
   // frame events
   input  wire sclt_pkg::sclt_rx_type      rxEvt [PORTS],
   input  wire sclt_pkg::sclt_tx_type      txEvt [PORTS],
   // learned table port
   output logic                            tableRdReq,
   output logic      [9:0]                 tableRdAddr,
   input  wire logic                       tableRdValid,
   input  wire logic [71:0]                tableRdEntry,
   input  wire logic [10:0]                learnedCount
);

   localparam int NC = `SCLT_NUM_COUNTERS;

   // register port decode
   logic        wrCtl;
   logic        wrAddr;
   logic        dataHit;
   logic [3:0]  dataIdx;
   logic [7:0]  ctlQ;
   logic [7:0]  addrLoQ;
   logic [71:0] dataQ;
   logic [71:0] dataD;
   logic [7:0]  rdMux;
   logic [7:0]  dataIdxOfs;

   assign wrCtl      = regWr && (regAddr == `SCLT_REG_IND_CTL);
   assign wrAddr     = regWr && (regAddr == `SCLT_REG_IND_ADDR);
   assign dataHit    = (regAddr >= `SCLT_REG_DATA_FIRST)
                    && (regAddr <= `SCLT_REG_DATA_LAST);
   assign dataIdxOfs = regAddr - `SCLT_REG_DATA_FIRST;
   assign dataIdx    = dataIdxOfs[3:0];

   // byte k of the data window is entry bits 71-8k down
   assign rdMux = (regAddr == `SCLT_REG_IND_CTL)  ? ctlQ :
                  (regAddr == `SCLT_REG_IND_ADDR) ? addrLoQ :
                  dataHit ? dataQ[71 - 8*dataIdx -: 8] :
                  8'h00;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= rdMux;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctlQ    <= 8'h00;
         addrLoQ <= 8'h00;
      end else begin
         if (wrCtl) begin
            ctlQ <= regWrData;
         end
         if (wrAddr) begin
            addrLoQ <= regWrData;
         end
      end
   end

   // trigger decode, built from the new low byte on the write itself
   logic       isRead;
   logic [1:0] tblSel;
   logic [9:0] entryAddr;
   logic       trigLearned;
   logic       trigCounter;

   assign isRead      = ctlQ[`SCLT_CTL_READ_BIT];
   assign tblSel      = ctlQ[`SCLT_CTL_SEL_HI:`SCLT_CTL_SEL_LO];
   assign entryAddr   = {ctlQ[`SCLT_CTL_ADDR_HI:0], regWrData};
   assign trigLearned = wrAddr && isRead
                     && (tblSel == `SCLT_SEL_LEARNED);
   assign trigCounter = wrAddr && isRead
                     && (tblSel == `SCLT_SEL_COUNTERS);

   // counter storage and per-frame classification
   logic [31:0] cntQ [PORTS][NC];
   logic        cntValidQ;
   logic [10:0] maxLen;

   assign maxLen = maxLen1536 ? `SCLT_LEN_MAX_BIG : `SCLT_LEN_MAX_STD;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cntValidQ <= 1'b0;
      end else begin
         cntValidQ <= 1'b1;
      end
   end

   function automatic logic [NC-1:0] rxHits(sclt_pkg::sclt_rx_type e,
                                             logic [10:0] lim);
      logic short;
      logic long;
      logic legal;
      logic good;
      logic ctrl;
      logic [NC-1:0] h;
      short = e.len < `SCLT_LEN_MIN;
      long  = e.len > lim;
      legal = !short && !long;
      good  = legal && e.crcOk && !e.symErr && !e.dribble;
      ctrl  = e.etherType == `SCLT_ETYPE_CTRL;
      h     = '0;
      h[0]  = !e.highPrio;
      h[1]  = e.highPrio;
      h[2]  = short && e.crcOk;
      h[3]  = short && (!e.crcOk || e.symErr || e.dribble);
      h[4]  = long && e.crcOk && !e.symErr && !e.dribble
           && (e.len <= `SCLT_LEN_JABBER);
      h[5]  = (long && (!e.crcOk || e.symErr || e.dribble))
           || (e.len > `SCLT_LEN_JABBER);
      h[6]  = legal && e.symErr && e.preambleOk;
      h[7]  = legal && !e.dribble && !e.crcOk;
      h[8]  = legal && e.dribble && !e.crcOk;
      h[9]  = ctrl;
      h[10] = ctrl && e.daPause && e.crcOk && !short
           && (e.opcode == `SCLT_OPCODE_PAUSE);
      h[11] = good && e.bcast;
      h[12] = good && e.mcast && !e.bcast && !ctrl;
      h[13] = good && !e.mcast && !e.bcast;
      h[14] = e.len == `SCLT_LEN_MIN;
      h[15] = (e.len > 11'd64) && (e.len <= 11'd127);
      h[16] = (e.len >= 11'd128) && (e.len <= 11'd255);
      h[17] = (e.len >= 11'd256) && (e.len <= 11'd511);
      h[18] = (e.len >= 11'd512) && (e.len <= 11'd1023);
      h[19] = (e.len >= 11'd1024) && !long;
      return e.done ? h : '0;
   endfunction

   function automatic logic [NC-1:0] txHits(sclt_pkg::sclt_tx_type e);
      logic [NC-1:0] h;
      h     = '0;
      h[20] = e.done && e.good && !e.highPrio;
      h[21] = e.done && e.good && e.highPrio;
      h[22] = e.lateCol;
      h[23] = e.done && e.pause;
      return h;
   endfunction

   genvar gp;
   genvar gc;
   generate
      for (gp = 0; gp < PORTS; gp++) begin : g_port
         logic [NC-1:0] hit;
         assign hit = rxHits(rxEvt[gp], maxLen) | txHits(txEvt[gp]);
         for (gc = 0; gc < NC; gc++) begin : g_cnt
            // octet counters add the length, the rest count frames
            localparam bit OCTETS = (gc == 0) || (gc == 1)
                                 || (gc == 20) || (gc == 21);
            logic [30:0] amount;
            logic [30:0] sum;
            if (OCTETS && gc < 2) begin : g_rxo
               assign amount = {20'h00000, rxEvt[gp].len};
            end else if (OCTETS) begin : g_txo
               assign amount = {20'h00000, txEvt[gp].len};
            end else begin : g_one
               assign amount = 31'h00000001;
            end
            assign sum = {1'b0, cntQ[gp][gc][`SCLT_CW_VALUE_HI:0]} + amount;
            always_ff @(posedge clk_sys or posedge rst) begin
               if (rst) begin
                  cntQ[gp][gc] <= 32'h00000000;
               end else if (hit[gc]) begin
                  // overflow is sticky, the value wraps
                  cntQ[gp][gc][`SCLT_CW_OVF_BIT] <=
                     cntQ[gp][gc][`SCLT_CW_OVF_BIT] | sum[30];
                  cntQ[gp][gc][`SCLT_CW_VALUE_HI:0] <= sum[29:0];
               end
            end
         end
      end
   endgenerate

   // counter address lookup: port block from bits 9-5, slot from 4-0
   logic [4:0]  portBlk;
   logic [4:0]  slot;
   logic        cntMapped;
   logic [31:0] cntWord;
   int          portIdx;

   assign portBlk   = entryAddr[9:5];
   assign slot      = entryAddr[4:0];
   assign portIdx   = int'(portBlk) - 1;
   assign cntMapped = (portBlk != 5'h00) && (int'(portBlk) <= PORTS)
                   && (int'(slot) < NC);

   always_comb begin
      cntWord = 32'h00000000;
      if (cntMapped) begin
         cntWord = cntQ[portIdx][slot];
         cntWord[`SCLT_CW_VALID_BIT] = cntValidQ;
      end
   end

   // learned table fetch
   sclt_pkg::sclt_fetch_type stateQ;
   sclt_pkg::sclt_fetch_type stateD;
   logic [9:0]  fetchAddrQ;
   logic [71:0] entryView;
   logic [9:0]  countField;

   assign countField = learnedCount[9:0] - 10'h001;

   always_comb begin
      entryView = tableRdEntry;
      entryView[`SCLT_ENT_NOTRDY_BIT] = 1'b0;
      if (fetchAddrQ == `SCLT_ENT_FIRST_ADDR) begin
         if (learnedCount == 11'h000) begin
            entryView[`SCLT_ENT_EMPTY_BIT] = 1'b1;
            entryView[`SCLT_ENT_COUNT_HI:`SCLT_ENT_COUNT_LO] = 10'h000;
         end else begin
            entryView[`SCLT_ENT_EMPTY_BIT] = 1'b0;
            entryView[`SCLT_ENT_COUNT_HI:`SCLT_ENT_COUNT_LO] = countField;
         end
      end
   end

   always_comb begin
      stateD = stateQ;
      dataD  = dataQ;
      unique case (stateQ)
         sclt_pkg::SCLT_IDLE: begin
            if (trigLearned) begin
               stateD = sclt_pkg::SCLT_WAIT;
               dataD  = 72'h0;
               dataD[`SCLT_ENT_NOTRDY_BIT] = 1'b1;
            end else if (trigCounter) begin
               dataD = {40'h0000000000, cntWord};
            end
         end
         sclt_pkg::SCLT_WAIT: begin
            if (tableRdValid) begin
               stateD = sclt_pkg::SCLT_IDLE;
               dataD  = entryView;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stateQ     <= sclt_pkg::SCLT_IDLE;
         dataQ      <= 72'h0;
         fetchAddrQ <= 10'h000;
      end else begin
         stateQ <= stateD;
         dataQ  <= dataD;
         if (trigLearned && stateQ == sclt_pkg::SCLT_IDLE) begin
            fetchAddrQ <= entryAddr;
         end
      end
   end

   // one-cycle request, issued the cycle after the trigger
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tableRdReq <= 1'b0;
      end else begin
         tableRdReq <= trigLearned && (stateQ == sclt_pkg::SCLT_IDLE);
      end
   end

   assign tableRdAddr = fetchAddrQ;

endmodule // sclt_stats_table

// [tb/sclt_stats_table_assertions.sv]
// port-level checks on the learned table read of sclt_stats_table
// assumes a single clk_sys domain and asynchronous rst
`timescale 1ns/1ns

module sclt_stats_table_assertions #(
   parameter int PORTS = 1
) (
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  rst,
   // register port
   input wire logic [7:0]            regAddr,
   input wire logic                  regWr,
   input wire logic [7:0]            regWrData,
   input wire logic [7:0]            regRdData,
   // configuration
   input wire logic                  maxLen1536,
   // frame events
   input wire sclt_pkg::sclt_rx_type rxEvt [PORTS],
   input wire sclt_pkg::sclt_tx_type txEvt [PORTS],
   // learned table port
   input wire logic                  tableRdReq,
   input wire logic [9:0]            tableRdAddr,
   input wire logic                  tableRdValid,
   input wire logic [71:0]           tableRdEntry,
   input wire logic [10:0]           learnedCount
);
   logic [7:0] ctlQ;
   logic       pendQ;
   logic       trigLearned;
   logic [9:0] cntField;
   logic       ent0Q;
   logic [7:0] ent0ByteQ;

   assign trigLearned = regWr && regAddr == 8'h6f && ctlQ[4]
                        && ctlQ[3:2] == 2'h2;
   assign cntField = (learnedCount == 11'd0) ? 10'h000
                     : 10'(learnedCount - 11'd1);

   // count byte kept from the fill of entry zero: the host reads it
   // only after its ready poll, long after the fill
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctlQ <= 8'h00;
         pendQ <= 1'b0;
         ent0Q <= 1'b0;
         ent0ByteQ <= 8'h00;
      end else begin
         if (regWr && regAddr == 8'h6e) ctlQ <= regWrData;
         if (tableRdReq) pendQ <= 1'b1;
         else if (tableRdValid) pendQ <= 1'b0;
         if (tableRdValid && pendQ && tableRdAddr == 10'h000) begin
            ent0Q <= 1'b1;
            ent0ByteQ <= {learnedCount == 11'd0, cntField[9:3]};
         end else if (regWr && regAddr == 8'h6f) begin
            ent0Q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_filled;
      tableRdValid && pendQ ##1 regAddr == 8'h72 && !regWr;
   endsequence
   sequence s_entry0;
      ent0Q && regAddr == 8'h70 && !regWr;
   endsequence

   a_req_after_trigger: assert property
      (trigLearned && !pendQ && !tableRdReq |=> tableRdReq)
      else $error("no fetch after trigger");
   a_req_has_cause: assert property
      (tableRdReq |-> $past(trigLearned))
      else $error("fetch without trigger");
   a_req_one_cycle: assert property
      (tableRdReq |=> !tableRdReq)
      else $error("fetch pulse too long");
   a_no_req_pending: assert property
      (pendQ |-> !tableRdReq)
      else $error("second fetch while pending");
   a_addr_from_regs: assert property
      (tableRdReq |-> tableRdAddr == {ctlQ[1:0], $past(regWrData)})
      else $error("entry address wrong");
   a_addr_stable: assert property
      (!tableRdReq |-> $stable(tableRdAddr))
      else $error("entry address moved");
   a_notready_set: assert property
      (pendQ && !tableRdValid && regAddr == 8'h72 |=> regRdData[7])
      else $error("ready shown too early");
   a_notready_clear: assert property
      (s_filled |=> !regRdData[7])
      else $error("ready flag stuck");
   a_count_field: assert property
      (s_entry0 |=> regRdData == ent0ByteQ)
      else $error("entry count byte wrong");
endmodule // sclt_stats_table_assertions

bind sclt_stats_table sclt_stats_table_assertions #(.PORTS(PORTS)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWr(regWr),
   .regWrData(regWrData), .regRdData(regRdData), .maxLen1536(maxLen1536),
   .rxEvt(rxEvt), .txEvt(txEvt), .tableRdReq(tableRdReq),
   .tableRdAddr(tableRdAddr), .tableRdValid(tableRdValid),
   .tableRdEntry(tableRdEntry), .learnedCount(learnedCount));

// [tb/sclt_table_model.sv]
// learned table store seen from the block's table port
// assumes one fetch outstanding, all on clk_sys
`timescale 1ns/1ns

module sclt_table_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // table port
   input  wire logic        tableRdReq,
   input  wire logic [9:0]  tableRdAddr,
   input  wire logic        slow,
   output logic             tableRdValid,
   output logic      [71:0] tableRdEntry
);
   logic [3:0]  waitQ;
   logic        busyQ;
   logic [71:0] staleQ;
   logic [71:0] entry;

   // not-ready flag comes up set; the block must clear it
   assign entry = {2'b10, {7{tableRdAddr}}} | (72'h1 << 55);
   // idle data toggles so stale bytes never pass for the entry
   assign tableRdEntry = tableRdValid ? entry : staleQ;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busyQ <= 1'b0;
         waitQ <= 4'h0;
         tableRdValid <= 1'b0;
         staleQ <= 72'h0;
      end else begin
         tableRdValid <= 1'b0;
         staleQ <= ~staleQ;
         if (tableRdReq) begin
            busyQ <= 1'b1;
            waitQ <= slow ? 4'h9 : 4'h0;
         end else if (busyQ && waitQ != 4'h0) begin
            waitQ <= waitQ - 4'h1;
         end else if (busyQ) begin
            busyQ <= 1'b0;
            tableRdValid <= 1'b1;
         end
      end
   end
endmodule // sclt_table_model

// [tb/tb_sclt_stats_table.sv]
// self-checking bench for sclt_stats_table with the table store model
// assumes port 1 only, counters zero after reset
`timescale 1ns/1ns

module tb_sclt_stats_table;
   logic                  clk_sys, rst, regWr, maxLen1536, slow;
   logic [7:0]            regAddr, regWrData, regRdData, rdByte;
   logic                  tableRdReq, tableRdValid;
   logic [9:0]            tableRdAddr;
   logic [71:0]           tableRdEntry;
   logic [10:0]           learnedCount;
   sclt_pkg::sclt_rx_type rxEvt [1];
   sclt_pkg::sclt_tx_type txEvt [1];
   logic [29:0]           expCnt [24];
   sclt_pkg::sclt_rx_type symFrm;
   int                    errors, tests_run;

   sclt_stats_table #(.PORTS(1)) i_dut (.clk_sys(clk_sys), .rst(rst),
      .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
      .regRdData(regRdData), .maxLen1536(maxLen1536), .rxEvt(rxEvt),
      .txEvt(txEvt), .tableRdReq(tableRdReq), .tableRdAddr(tableRdAddr),
      .tableRdValid(tableRdValid), .tableRdEntry(tableRdEntry),
      .learnedCount(learnedCount));
   sclt_table_model i_model (.clk_sys(clk_sys), .rst(rst),
      .tableRdReq(tableRdReq), .tableRdAddr(tableRdAddr), .slow(slow),
      .tableRdValid(tableRdValid), .tableRdEntry(tableRdEntry));

   task automatic chk(string what, logic [71:0] seen, logic [71:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask

   // read data lags the address by one edge
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      @(posedge clk_sys);
      #1 d = regRdData;
   endtask

   task automatic t_learned(logic [9:0] a, logic s, logic [10:0] lc);
      logic [71:0] got, exp;
      int n;
      @(posedge clk_sys);
      slow <= s;
      learnedCount <= lc;
      exp = {2'b10, {7{a}}};
      exp[55] = 1'b0;
      if (a == 10'h000) begin
         exp[71] = (lc == 11'd0);
         exp[70:61] = (lc == 11'd0) ? 10'h000 : 10'(lc - 11'd1);
      end
      wr(8'h6e, {6'h06, a[9:8]});
      wr(8'h6f, a[7:0]);
      n = 0;
      do begin
         rd(8'h72, rdByte);
         n++;
      end while (rdByte[7] && n < 30);
      if (rdByte[7]) begin
         errors++;
         wrap_up();
      end
      if (s) chk("retry seen", n > 1, 1'b1);
      for (int i = 0; i < 9; i++) begin
         rd(8'h70 + 8'(i), rdByte);
         got[71 - 8*i -: 8] = rdByte;
      end
      chk("learned entry", got, exp);
   endtask

   task automatic check_all;
      logic [31:0] w;
      string       nm;
      for (int i = 0; i < 24; i++) begin
         wr(8'h6e, 8'h1c);
         wr(8'h6f, 8'h20 + 8'(i));
         for (int k = 0; k < 4; k++) begin
            rd(8'h75 + 8'(k), rdByte);
            w[31 - 8*k -: 8] = rdByte;
         end
         nm = $sformatf("counter %0h", 32 + i);
         chk(nm, w, {2'b01, expCnt[i]});
      end
   endtask

   // one event, then every port-1 counter is read back
   task automatic t_frame(logic big, sclt_pkg::sclt_rx_type r,
                          sclt_pkg::sclt_tx_type t, logic [23:0] m);
      @(posedge clk_sys);
      maxLen1536 <= big;
      rxEvt[0] <= r;
      txEvt[0] <= t;
      @(posedge clk_sys);
      rxEvt[0] <= '0;
      txEvt[0] <= '0;
      for (int i = 0; i < 24; i++) begin
         if (m[i]) expCnt[i] += (i < 2) ? 30'(r.len)
            : (i == 20 || i == 21) ? 30'(t.len) : 30'd1;
      end
      check_all();
   endtask

   function automatic sclt_pkg::sclt_rx_type rx(logic [10:0] len,
      logic ok, logic drb, logic hi, logic bc, logic mc, logic ctl);
      return '{1'b1, len, ok, 1'b0, drb, 1'b1, hi, bc, mc,
               ctl ? 16'h8808 : 16'h0800, {15'h0, ctl}, ctl};
   endfunction

   function automatic sclt_pkg::sclt_tx_type tx(logic [10:0] len,
      logic hi, logic pz, logic lc);
      return '{!lc, len, 1'b1, hi, pz, lc};
   endfunction

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      rst = 1'b1;
      {regAddr, regWr, regWrData, maxLen1536, slow, learnedCount} = '0;
      rxEvt[0] = '0;
      txEvt[0] = '0;
      errors = 0;
      tests_run = 0;
      foreach (expCnt[i]) expCnt[i] = '0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd(8'h80, rdByte);
      chk("unmapped read", rdByte, 8'h00);
      check_all();
      t_learned(10'h000, 1'b0, 11'd0);
      t_learned(10'h000, 1'b1, 11'd1024);
      t_learned(10'h101, 1'b1, 11'd5);
      t_learned(10'h3ff, 1'b0, 11'd1);
      t_frame(0, rx(64, 1, 0, 0, 0, 0, 0), '0, 24'h006001);
      t_frame(0, rx(150, 1, 0, 1, 1, 0, 0), '0, 24'h010802);
      t_frame(0, rx(100, 1, 0, 0, 0, 1, 1), '0, 24'h008601);
      t_frame(0, rx(40, 0, 0, 0, 0, 0, 0), '0, 24'h000009);
      t_frame(0, rx(40, 1, 0, 0, 0, 0, 0), '0, 24'h000005);
      t_frame(0, rx(70, 1, 0, 0, 0, 1, 0), '0, 24'h009001);
      symFrm = rx(200, 1, 0, 0, 0, 0, 0);
      symFrm.symErr = 1'b1;
      t_frame(0, symFrm, '0, 24'h010041);
      t_frame(0, rx(300, 0, 0, 0, 0, 0, 0), '0, 24'h020081);
      t_frame(0, rx(600, 0, 1, 0, 0, 0, 0), '0, 24'h040101);
      t_frame(1, rx(1530, 1, 0, 0, 0, 0, 0), '0, 24'h082001);
      t_frame(0, rx(1530, 0, 0, 0, 0, 0, 0), '0, 24'h000021);
      t_frame(0, rx(1530, 1, 0, 0, 0, 0, 0), '0, 24'h000011);
      t_frame(1, rx(1920, 1, 0, 0, 0, 0, 0), '0, 24'h000021);
      t_frame(0, '0, tx(64, 0, 1, 0), 24'h900000);
      t_frame(0, '0, tx(100, 1, 0, 0), 24'h200000);
      t_frame(0, '0, tx(0, 0, 0, 1), 24'h400000);
      wrap_up();
   end
endmodule // tb_sclt_stats_table
